// >>> logic/mirq_pkg.sv
// Purpose: shared constants for the meter event and configuration registers
// Assumes: plain register port, 8-bit register index, 16-bit data
// Notes: offsets are register indexes on the plain port
package mirq_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;
  localparam int unsigned NFLAG = 16;
  localparam logic [7:0] OFS_MODE = 8'h09;
  localparam logic [7:0] OFS_IRQEN = 8'h0a;
  localparam logic [7:0] OFS_STATUS = 8'h0b;
  localparam logic [7:0] OFS_RSTATUS = 8'h0c;
  localparam logic [7:0] OFS_CHAN1_OFFSET_INTEGRATOR = 8'h0d;
  localparam logic [15:0] MODE_RESET = 16'h000c;
  localparam logic [15:0] IRQEN_RESET = 16'h0040;
  localparam logic [7:0] CHAN1_OFFSET_INTEGRATOR_RESET = 8'h00;
  // mode field positions
  localparam int unsigned MODE_WAVSEL_LO = 13;
  localparam int unsigned MODE_WAVSEL_HI = 14;
  localparam int unsigned MODE_POS_ONLY = 15;
  // status flag positions
  localparam int unsigned FL_RESET = 6;
  localparam logic [15:0] FLAG_VALID = 16'h7fff;
  localparam logic [15:0] FLAG_NOIRQ = 16'h0040;
  // offset register fields
  localparam int unsigned OS_MAG_HI = 4;
  localparam int unsigned OS_SIGN = 5;
  localparam int unsigned OS_INTEG = 7;
  localparam int unsigned OS_W = 8;
  typedef enum logic [1:0] {
    MIRQ_SRC_POWER = 2'b00,
    MIRQ_SRC_RSVD = 2'b01,
    MIRQ_SRC_CH1 = 2'b10,
    MIRQ_SRC_CH2 = 2'b11
  } mirq_src_t;
  typedef enum logic [1:0] {
    MIRQ_ST_BOOT = 2'b00,
    MIRQ_ST_RUN = 2'b01
  } mirq_state_t;
endpackage : mirq_pkg

// >>> logic/mirq_flags.sv
// Purpose: sticky event flags with set-over-clear priority
// Assumes: events are one-cycle pulses on mclk
// Notes: one generate slice per flag
`timescale 1ns/10ps
module mirq_flags
  import mirq_pkg::*;
#(
  parameter int unsigned N = NFLAG
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [N-1:0] set_i,
  input wire logic clr_all,
  input wire logic [N-1:0] valid_mask,
  output logic [N-1:0] flags_q
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_ff @(posedge mclk) begin
        if (srst) begin
          flags_q[g] <= 1'b0;
        end else if (set_i[g] && valid_mask[g]) begin
          // a new event beats a read-clear in the same cycle
          flags_q[g] <= 1'b1;
        end else if (clr_all) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : mirq_flags

// >>> logic/mirq_edge.sv
// Purpose: sign-change detector for the power sign input
// Assumes: sign input from same-clock logic, valid with its strobe
// Notes: first sample after reset only primes the history
`timescale 1ns/10ps
module mirq_edge (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sample_stb,
  input wire logic negative,
  output logic to_pos,
  output logic to_neg
);
  logic last_neg_q;
  logic primed_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      last_neg_q <= 1'b0;
      primed_q <= 1'b0;
    end else if (sample_stb) begin
      last_neg_q <= negative;
      primed_q <= 1'b1;
    end
  end
  assign to_pos = sample_stb && primed_q && last_neg_q && !negative;
  assign to_neg = sample_stb && primed_q && !last_neg_q && negative;
endmodule : mirq_edge

// >>> logic/mirq_regs.sv
// Purpose: mode, interrupt and channel-1 offset registers of the meter
// Assumes: one 10 MHz clock, synchronous reset, event inputs on mclk
// Notes: reads return data one cycle after the read strobe
`timescale 1ns/10ps
module mirq_regs
  import mirq_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rdata,
  // event inputs, one-cycle pulses from the metering datapath, then the power sign level and its sample strobe
  input wire logic active_energy_half,
  input wire logic line_dip,
  input wire logic line_cycle_done,
  input wire logic waveform_sample,
  input wire logic zero_cross,
  input wire logic temp_done,
  input wire logic active_energy_overflow,
  input wire logic voltage_peak,
  input wire logic current_peak,
  input wire logic apparent_energy_half,
  input wire logic apparent_energy_overflow,
  input wire logic zero_cross_timeout,
  input wire logic power_sample_stb,
  input wire logic power_negative,
  // configuration outputs and the open-drain interrupt pin
  output logic [1:0] waveform_source_select,
  output logic positive_only_accumulate,
  output logic [15:0] mode_bits,
  output logic [4:0] offset_magnitude,
  output logic offset_negative,
  output logic integrator_on,
  output logic irq_n_o,
  output logic irq_n_oe
);
  logic [DW-1:0] mode_q;
  logic [DW-1:0] irqen_q;
  logic [OS_W-1:0] chan1_offset_integrator_q;
  logic [NFLAG-1:0] flags_q;
  logic [NFLAG-1:0] set_vec;
  logic reset_evt;
  logic clr_rd;
  logic to_pos;
  logic to_neg;
  logic irq_n_q;
  mirq_state_t state_q;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // reset flag fires once, in the first cycle after reset is released
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= MIRQ_ST_BOOT;
    end else begin
      case (state_q)
        MIRQ_ST_BOOT: state_q <= MIRQ_ST_RUN;
        MIRQ_ST_RUN: state_q <= MIRQ_ST_RUN;
        default: state_q <= MIRQ_ST_RUN;
      endcase
    end
  end
  assign reset_evt = (state_q == MIRQ_ST_BOOT) && !srst;

  mirq_edge u_edge (
    .mclk(mclk),
    .srst(srst),
    .sample_stb(power_sample_stb),
    .negative(power_negative),
    .to_pos(to_pos),
    .to_neg(to_neg)
  );

  always_comb begin
    set_vec = '0;
    set_vec[0] = active_energy_half;
    set_vec[1] = line_dip;
    set_vec[2] = line_cycle_done;
    set_vec[3] = waveform_sample;
    set_vec[4] = zero_cross;
    set_vec[5] = temp_done;
    set_vec[FL_RESET] = reset_evt;
    set_vec[7] = active_energy_overflow;
    set_vec[8] = voltage_peak;
    set_vec[9] = current_peak;
    set_vec[10] = apparent_energy_half;
    set_vec[11] = apparent_energy_overflow;
    set_vec[12] = zero_cross_timeout;
    set_vec[13] = to_pos;
    set_vec[14] = to_neg;
  end

  assign clr_rd = rd_stb && hit(addr, OFS_RSTATUS);

  mirq_flags #(
    .N(NFLAG)
  ) u_flags (
    .mclk(mclk),
    .srst(srst),
    .set_i(set_vec),
    .clr_all(clr_rd),
    .valid_mask(FLAG_VALID),
    .flags_q(flags_q)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= MODE_RESET;
    end else if (wr_stb && hit(addr, OFS_MODE)) begin
      mode_q <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irqen_q <= IRQEN_RESET;
    end else if (wr_stb && hit(addr, OFS_IRQEN)) begin
      irqen_q <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      chan1_offset_integrator_q <= CHAN1_OFFSET_INTEGRATOR_RESET;
    end else if (wr_stb && hit(addr, OFS_CHAN1_OFFSET_INTEGRATOR)) begin
      chan1_offset_integrator_q <= wdata[OS_W-1:0];
    end
  end

  // read data valid only in the cycle after the strobe; the clear of
  // the read-clear address lands on the same edge the data is captured
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      case (addr)
        OFS_MODE: rdata <= mode_q;
        OFS_IRQEN: rdata <= irqen_q;
        OFS_STATUS: rdata <= flags_q;
        OFS_RSTATUS: rdata <= flags_q;
        OFS_CHAN1_OFFSET_INTEGRATOR: rdata <= {{(DW-OS_W){1'b0}}, chan1_offset_integrator_q};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // the reset flag is masked out so its enable bit does nothing
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(flags_q & irqen_q & ~FLAG_NOIRQ);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      waveform_source_select <= MODE_RESET[MODE_WAVSEL_HI:MODE_WAVSEL_LO];
      positive_only_accumulate <= MODE_RESET[MODE_POS_ONLY];
      mode_bits <= MODE_RESET;
      offset_magnitude <= CHAN1_OFFSET_INTEGRATOR_RESET[OS_MAG_HI:0];
      offset_negative <= CHAN1_OFFSET_INTEGRATOR_RESET[OS_SIGN];
      integrator_on <= CHAN1_OFFSET_INTEGRATOR_RESET[OS_INTEG];
    end else begin
      waveform_source_select <= mode_q[MODE_WAVSEL_HI:MODE_WAVSEL_LO];
      positive_only_accumulate <= mode_q[MODE_POS_ONLY];
      mode_bits <= mode_q;
      offset_magnitude <= chan1_offset_integrator_q[OS_MAG_HI:0];
      offset_negative <= chan1_offset_integrator_q[OS_SIGN];
      integrator_on <= chan1_offset_integrator_q[OS_INTEG];
    end
  end

  // open drain: drive only while pulling low
  assign irq_n_o = irq_n_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_n_oe <= 1'b0;
    end else begin
      irq_n_oe <= |(flags_q & irqen_q & ~FLAG_NOIRQ);
    end
  end

  // assertions
  sequence enabled_flag_s;
    |(flags_q & irqen_q & ~FLAG_NOIRQ);
  endsequence

  irq_follow_a: assert property (@(posedge mclk) disable iff (srst)
    enabled_flag_s |=> !irq_n_q && irq_n_oe)
    else $error("irq not asserted for enabled flag");

  irq_idle_a: assert property (@(posedge mclk) disable iff (srst)
    !(|(flags_q & irqen_q & ~FLAG_NOIRQ)) |=> irq_n_q && !irq_n_oe)
    else $error("irq asserted with no enabled flag");

  flag_set_a: assert property (@(posedge mclk) disable iff (srst)
    zero_cross |=> flags_q[4])
    else $error("zero cross flag not set");

  rd_clear_a: assert property (@(posedge mclk) disable iff (srst)
    (clr_rd && set_vec == '0) |=> flags_q == '0 && rdata == $past(flags_q))
    else $error("read-clear did not clear or return flags");

  rd_keep_a: assert property (@(posedge mclk) disable iff (srst)
    (rd_stb && addr == OFS_STATUS && set_vec == '0)
      |=> flags_q == $past(flags_q)
      && rdata == $past(flags_q))
    else $error("plain status read changed flags");

  reset_flag_a: assert property (@(posedge mclk)
    $fell(srst) |=> flags_q[FL_RESET])
    else $error("reset flag not set after reset");

  rsvd_a: assert property (@(posedge mclk) disable iff (srst)
    !flags_q[15])
    else $error("reserved flag set");

  wavsel_a: assert property (@(posedge mclk) disable iff (srst)
    (wr_stb && addr == OFS_MODE) |=> ##1 waveform_source_select
      == $past(wdata[MODE_WAVSEL_HI:MODE_WAVSEL_LO], 2))
    else $error("waveform source not taken from mode write");

  integ_a: assert property (@(posedge mclk) disable iff (srst)
    (wr_stb && addr == OFS_CHAN1_OFFSET_INTEGRATOR) |=> ##1 integrator_on
      == $past(wdata[OS_INTEG], 2) && offset_negative
      == $past(wdata[OS_SIGN], 2))
    else $error("offset register fields not applied");

  pos_edge_a: assert property (@(posedge mclk) disable iff (srst)
    to_pos |=> flags_q[13])
    else $error("power to positive flag missed");
endmodule : mirq_regs

// >>> testbench/mirq_host.sv
// Purpose: host microcontroller model on the plain register port
// Assumes: one access at a time, strobes driven just after mclk rises
// Notes: read data are taken in the one cycle that they stand
`timescale 1ns/10ps
module mirq_host
  import mirq_pkg::*;
(
  input wire logic mclk,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [DW-1:0] rdata
);
  initial begin
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // the cause is learned before anything clears it
  task automatic service(output logic [DW-1:0] st, output logic [DW-1:0] sc);
    rd(OFS_STATUS, st);
    rd(OFS_RSTATUS, sc);
  endtask : service
endmodule : mirq_host

// >>> testbench/tb_meter_irq_and_config_regs.sv
// Purpose: self-checking bench for the meter event and config registers
// Assumes: 10 MHz mclk, srst held two cycles at start
// Notes: event pulses and power sign samples come from this bench
`timescale 1ns/10ps
module tb_meter_irq_and_config_regs;
  import mirq_pkg::*;
  logic mclk, srst, wr_stb, rd_stb, pstb, power_to_negative_flag;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, mode_bits, d, e;
  logic [11:0] ev;
  logic [1:0] wsel;
  logic pos_only, ofs_neg, integ, irq_n, irq_oe;
  logic [4:0] ofs_mag;
  int fail_count, check_count, cyc;
  localparam int EVB [12] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12};
  localparam logic [7:0] OFSV [2] = '{8'ha5, 8'h3e};

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  mirq_host mirq_host_i (.mclk(mclk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

  mirq_regs mirq_regs_i (.mclk(mclk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .active_energy_half(ev[0]), .line_dip(ev[1]),
    .line_cycle_done(ev[2]), .waveform_sample(ev[3]),
    .zero_cross(ev[4]), .temp_done(ev[5]),
    .active_energy_overflow(ev[6]), .voltage_peak(ev[7]),
    .current_peak(ev[8]), .apparent_energy_half(ev[9]),
    .apparent_energy_overflow(ev[10]), .zero_cross_timeout(ev[11]),
    .power_sample_stb(pstb), .power_negative(power_to_negative_flag),
    .waveform_source_select(wsel), .positive_only_accumulate(pos_only),
    .mode_bits(mode_bits), .offset_magnitude(ofs_mag),
    .offset_negative(ofs_neg), .integrator_on(integ),
    .irq_n_o(irq_n), .irq_n_oe(irq_oe));

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic wait_out;
    repeat (3) @(posedge mclk);
    #1;
  endtask : wait_out

  task automatic psamp(input logic neg);
    @(posedge mclk);
    pstb <= 1'b1;
    power_to_negative_flag <= neg;
    @(posedge mclk);
    pstb <= 1'b0;
  endtask : psamp

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    srst = 1'b1;
    ev = '0;
    pstb = 1'b0;
    power_to_negative_flag = 1'b0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    mirq_host_i.rd(OFS_MODE, d);
    chk("mode", MODE_RESET, d);
    mirq_host_i.rd(OFS_IRQEN, d);
    chk("enable", IRQEN_RESET, d);
    mirq_host_i.rd(OFS_CHAN1_OFFSET_INTEGRATOR, d);
    chk("offset", 16'h0000, d);
    chk("irq", 16'h0001, {14'h0, irq_oe, irq_n});
    mirq_host_i.service(d, e);
    chk("status", 16'h0040, d);
    chk("status clr", 16'h0040, e);
    mirq_host_i.rd(OFS_STATUS, d);
    chk("status", 16'h0000, d);
    mirq_host_i.rd(8'h20, d);
    chk("unmapped", 16'h0000, d);
    for (int s = 0; s < 4; s++) begin
      d = {s[0], s[1:0], 13'h000c};
      mirq_host_i.wr(OFS_MODE, d);
      wait_out();
      chk("wsel", 16'(s[1:0]), {14'h0, wsel});
      chk("pos only", 16'(s[0]), {15'h0, pos_only});
      chk("mode bits", d, mode_bits);
      mirq_host_i.rd(OFS_MODE, e);
      chk("mode", d, e);
    end
    for (int i = 0; i < 2; i++) begin
      mirq_host_i.wr(OFS_CHAN1_OFFSET_INTEGRATOR, {8'h00, OFSV[i]});
      wait_out();
      chk("magnitude", 16'(OFSV[i][4:0]), 16'(ofs_mag));
      chk("sign", 16'(OFSV[i][5]), 16'(ofs_neg));
      chk("integrator", 16'(OFSV[i][7]), 16'(integ));
      mirq_host_i.rd(OFS_CHAN1_OFFSET_INTEGRATOR, d);
      chk("offset", {8'h00, OFSV[i]}, d);
    end
    mirq_host_i.wr(OFS_IRQEN, 16'h7fff);
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      ev <= 12'h001 << i;
      @(posedge mclk);
      ev <= '0;
      wait_out();
      chk("irq", 16'h0002, {14'h0, irq_oe, irq_n});
      mirq_host_i.service(d, e);
      chk("status", 16'h0001 << EVB[i], d);
      chk("status clr", 16'h0001 << EVB[i], e);
      @(posedge mclk);
      #1;
      chk("irq", 16'h0001, {14'h0, irq_oe, irq_n});
    end
    mirq_host_i.wr(OFS_IRQEN, 16'h0000);
    @(posedge mclk);
    ev <= 12'h001;
    @(posedge mclk);
    ev <= '0;
    wait_out();
    chk("irq", 16'h0001, {14'h0, irq_oe, irq_n});
    mirq_host_i.rd(OFS_STATUS, d);
    mirq_host_i.rd(OFS_STATUS, e);
    chk("status", 16'h0001, e);
    mirq_host_i.rd(OFS_RSTATUS, d);
    psamp(1'b0);
    psamp(1'b1);
    wait_out();
    mirq_host_i.service(d, e);
    chk("to neg", 16'h4000, e);
    psamp(1'b0);
    wait_out();
    mirq_host_i.service(d, e);
    chk("to pos", 16'h2000, e);
    close_out();
  end
endmodule : tb_meter_irq_and_config_regs
